/* bench/testbench.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: One wait state per access; conversion spans 480 clocks
// Notes:   Register model kept in bench variables, compared per access
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench import adcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_b, i_read, i_write, i_idle_mode, i_pdown_mode;
  logic [ADDR_W-1:0] i_address;
  logic [DATA_W-1:0] i_writedata, o_readdata, rd;
  logic [3:0] i_byteenable;
  logic o_waitrequest, o_irq, o_conv_active, o_converter_enable;
  logic [7:0] i_sample_data, smp;
  logic [NUM_CHAN-1:0] i_pin_level, o_pin_digital_en, pins, oh;
  logic [2:0] o_chan_sel, ch, m_chan;
  bit m_en, m_start, m_done;
  logic [7:0] m_res;
  int errors, n_checks, act_cnt, a0, n;

  adcc_ctrl adcc_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_sample_data(i_sample_data), .i_pin_level(i_pin_level),
    .i_idle_mode(i_idle_mode), .i_pdown_mode(i_pdown_mode),
    .o_irq(o_irq), .o_conv_active(o_conv_active), .o_chan_sel(o_chan_sel),
    .o_converter_enable(o_converter_enable),
    .o_pin_digital_en(o_pin_digital_en));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Clocks with conversion active, to measure length and spot restarts
  always @(posedge i_clk) begin
    if (o_conv_active === 1'b1) act_cnt <= act_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Bus and model tasks
  // ----------------------------------------------------------------
  task automatic bus(input bit wr, input logic [3:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 50);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    if (k >= 50) errors++;
  endtask

  task automatic wcs(input logic [7:0] d);
    bit idle;
    idle = !m_start && !m_done;
    if (idle) m_chan = d[2:0];
    if (idle && m_en && d[3]) m_start = 1'b1;
    m_en = d[5];
    bus(1'b1, ADDR_CS, {24'h0, d});
  endtask

  task automatic chk_cs;
    bus(1'b0, ADDR_CS, 32'h0);
    `CHK("cs", {24'h0, 2'b11, m_en, m_done, m_start, m_chan}, rd)
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_read, i_write, i_idle_mode, i_pdown_mode} = 4'h0;
    i_rst_b = 1'b0;
    i_address = 4'h0;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    i_sample_data = 8'h00;
    i_pin_level = 5'h00;
    act_cnt = 0;
    m_chan = 3'h0;
    void'($urandom(32'h1E447085));
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    `CHK("digen", 5'h1F, o_pin_digital_en)
    `CHK("en", 1'b0, o_converter_enable)
    chk_cs();
    bus(1'b0, ADDR_RESULT, 32'h0);
    `CHK("res", 32'h0, rd)
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    i_byteenable <= 4'h0;
    bus(1'b1, ADDR_CS, 32'h20);
    i_byteenable <= 4'hF;
    chk_cs();
    for (int c = 0; c < 5; c++) begin
      pins = 5'($urandom);
      oh = 5'(1 << c);
      @(posedge i_clk) i_pin_level <= pins;
      wcs(8'(8'h20 | c));
      bus(1'b0, ADDR_PINS, 32'h0);
      `CHK("pins", {27'h0, pins | oh}, rd)
      `CHK("digen", ~oh, o_pin_digital_en)
      `CHK("chan", 3'(c), o_chan_sel)
      wcs(8'(8'h10 | c));
      bus(1'b0, ADDR_PINS, 32'h0);
      `CHK("pins", {27'h0, pins}, rd)
      `CHK("digen", 5'h1F, o_pin_digital_en)
      chk_cs();
    end
    bus(1'b1, ADDR_IRQEN, 32'h1);
    bus(1'b0, ADDR_IRQEN, 32'h0);
    `CHK("irqen", 32'h1, rd)
    wcs(8'h25);
    bus(1'b0, ADDR_PINS, 32'h0);
    `CHK("pins5", {27'h0, pins}, rd)
    `CHK("digen5", 5'h1F, o_pin_digital_en)
    `CHK("chan5", 3'h5, o_chan_sel)
    // Full conversion with refused requests while busy
    ch = 3'($urandom % 5);
    smp = 8'($urandom);
    @(posedge i_clk) i_sample_data <= smp;
    wcs(8'h20 | 8'(ch));
    a0 = act_cnt;
    wcs(8'h28 | 8'(ch));
    chk_cs();
    wcs(8'h20 | 8'(ch + 3'h1));
    chk_cs();
    wcs(8'h28 | 8'(ch + 3'h1));
    n = 0;
    do begin
      bus(1'b0, ADDR_CS, 32'h0);
      `CHK("both", 1'b0, rd[4] & rd[3])
      n++;
    end while (rd[4] !== 1'b1 && n < 400);
    `CHK("done", 1'b1, rd[4])
    m_start = 1'b0;
    m_done = 1'b1;
    m_res = smp;
    @(posedge i_clk) i_sample_data <= ~smp;
    `CHK("len", OSC_PER_MC * CONV_MC, act_cnt - a0)
    `CHK("irq", 1'b1, o_irq)
    wcs(8'h28 | 8'(ch));
    chk_cs();
    @(posedge i_clk) i_idle_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk_cs();
    bus(1'b0, ADDR_RESULT, 32'h0);
    `CHK("res", {24'h0, m_res}, rd)
    m_done = 1'b0;
    i_idle_mode <= 1'b0;
    chk_cs();
    `CHK("irq", 1'b0, o_irq)
    a0 = act_cnt;
    repeat (600) @(posedge i_clk);
    `CHK("queued", a0, act_cnt)
    chk_cs();
    // Abort by idle, then by power-down
    for (int md = 0; md < 2; md++) begin
      wcs(8'h28 | 8'(ch));
      a0 = act_cnt;
      repeat (40) @(posedge i_clk);
      @(posedge i_clk) {i_pdown_mode, i_idle_mode} <= md ? 2'b10 : 2'b01;
      repeat (2) @(posedge i_clk);
      {i_pdown_mode, i_idle_mode} <= 2'b00;
      m_start = 1'b0;
      chk_cs();
      repeat (600) @(posedge i_clk);
      `CHK("abort", 1'b1, (act_cnt - a0) < 480)
      chk_cs();
    end
    give_verdict();
  end
endmodule

/* logic/adcc_conv_timer.sv */
// Purpose: Machine-cycle timer that paces one conversion
// Assumes: i_run stays high for the whole conversion
// Notes:   o_last is combinational, high in the final busy cycle
module adcc_conv_timer
  import adcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_run,
  output logic o_last
);

  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [5:0] mc_q;
  logic [5:0] mc_d;
  logic pre_wrap;

  // --------------------------------------------------------------
  // Prescale and machine-cycle count
  // --------------------------------------------------------------
  assign pre_wrap = (pre_q == PRE_LAST);
  assign o_last = i_run && pre_wrap && (mc_q == MC_LAST);
  // Dropping i_run restarts from zero, which is how abort works
  assign pre_d = !i_run ? 4'h0 : (pre_wrap ? 4'h0 : pre_q + 4'h1);
  assign mc_d = !i_run ? 6'h00 : (pre_wrap ? mc_q + 6'h01 : mc_q);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_q <= 4'h0;
      mc_q <= 6'h00;
    end else begin
      pre_q <= pre_d;
      mc_q <= mc_d;
    end
  end

endmodule

/* logic/adcc_ctrl.sv */
// Purpose: Converter control, status and result over Avalon-MM
// Assumes: Analog core presents i_sample_data when a conversion ends
// Notes:   One wait state on every access; read data registered
//
// Our own choices: the register offsets and the Avalon-MM slave port.
module adcc_ctrl
  import adcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [7:0] i_sample_data,
  input wire logic [NUM_CHAN-1:0] i_pin_level,
  input wire logic i_idle_mode,
  input wire logic i_pdown_mode,
  output logic o_irq,
  output logic o_conv_active,
  output logic [2:0] o_chan_sel,
  output logic o_converter_enable,
  output logic [NUM_CHAN-1:0] o_pin_digital_en
);

  adcc_state_t state_q;
  adcc_state_t state_d;
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic en_q;
  logic ien_q;
  logic [2:0] chan_q;
  logic [7:0] result_q;
  logic irq_q;
  logic active_q;
  logic [NUM_CHAN-1:0] dig_en_q;
  logic [8:0] busy_len_q;
  logic [8:0] busy_len_d;

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic lane0;
  logic cs_wr;
  logic ien_wr;
  logic result_rd;
  logic conv_start_bit;
  logic conv_done_flag;
  logic abort;
  logic start_req;
  logic chan_wr;
  logic conv_last;
  logic [4:0] chan_mask;
  logic [7:0] cs_view;
  logic [NUM_CHAN-1:0] pin_view;
  logic [NUM_CHAN-1:0] dig_en_d;
  logic [DATA_W-1:0] rd_mux;

  assign req = i_read || i_write;
  // Access completes in the cycle where waitrequest reads low
  assign acc = req && !wait_q;
  assign wr_acc = acc && i_write;
  assign rd_acc = acc && i_read;
  assign lane0 = i_byteenable[0];
  assign cs_wr = wr_acc && lane0 && (i_address == ADDR_CS);
  assign ien_wr = wr_acc && lane0 && (i_address == ADDR_IRQEN);
  assign result_rd = rd_acc && (i_address == ADDR_RESULT);

  // --------------------------------------------------------------
  // Status view
  // --------------------------------------------------------------
  assign conv_start_bit = (state_q == ST_BUSY);
  assign conv_done_flag = (state_q == ST_DONE);
  assign abort = i_idle_mode || i_pdown_mode;
  assign chan_mask = adcc_onehot(chan_q);
  assign cs_view = CS_RSVD | {2'h0, en_q, conv_done_flag,
                              conv_start_bit, chan_q};
  // Selected channel reads high while the converter owns it
  assign pin_view = i_pin_level | (en_q ? chan_mask : 5'h00);
  assign dig_en_d = en_q ? ~chan_mask : PINS_ALL;

  assign rd_mux =
    (i_address == ADDR_CS) ? {24'h000000, cs_view} :
    (i_address == ADDR_RESULT) ? {24'h000000, result_q} :
    (i_address == ADDR_IRQEN) ? {31'h00000000, ien_q} :
    (i_address == ADDR_PINS) ? {27'h0000000, pin_view} :
    32'h00000000;

  // --------------------------------------------------------------
  // Start and channel control
  // --------------------------------------------------------------
  // Start is honoured only from idle; elsewhere it is simply lost
  assign start_req = cs_wr && i_writedata[BIT_START] && en_q
                     && !abort;
  assign chan_wr = cs_wr && (state_q == ST_IDLE);

  adcc_conv_timer u_timer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_run(conv_start_bit),
    .o_last(conv_last)
  );

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // Starts here are ignored; software cannot clear start
        if (abort) begin
          state_d = ST_IDLE;
        end else if (conv_last) begin
          state_d = ST_POST;
        end
      end
      ST_POST: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        // Starts refused; idle entry leaves result alone
        if (result_rd) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign busy_len_d = conv_start_bit ? busy_len_q + 9'h001 :
                      (state_q == ST_POST) ? busy_len_q : 9'h000;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      busy_len_q <= 9'h000;
    end else begin
      state_q <= state_d;
      busy_len_q <= busy_len_d;
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_q <= 1'b0;
      ien_q <= 1'b0;
      chan_q <= CHAN_RST;
    end else begin
      if (cs_wr) begin
        en_q <= i_writedata[BIT_ENABLE];
      end
      if (ien_wr) begin
        ien_q <= i_writedata[BIT_IRQEN];
      end
      if (chan_wr) begin
        chan_q <= i_writedata[BIT_CHAN_HI:BIT_CHAN_LO];
      end
    end
  end

  // Captured once per conversion, so a held result cannot change
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_q <= RESULT_RST;
    end else if (state_q == ST_POST) begin
      result_q <= i_sample_data;
    end
  end

  // --------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !(req && wait_q);
      if (req && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------
  // Output flops
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_q <= 1'b0;
      active_q <= 1'b0;
      dig_en_q <= PINS_ALL;
    end else begin
      irq_q <= conv_done_flag && ien_q;
      active_q <= conv_start_bit;
      dig_en_q <= dig_en_d;
    end
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_irq = irq_q;
  assign o_conv_active = active_q;
  assign o_chan_sel = chan_q;
  assign o_converter_enable = en_q;
  assign o_pin_digital_en = dig_en_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_start_done_excl: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !(conv_start_bit && conv_done_flag))
    else $error("start and done both set");

  a_conv_length: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == ST_POST) |-> (busy_len_q == CONV_CLKS))
    else $error("conversion length wrong");

  a_irq_follows: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (conv_done_flag && ien_q) |=> o_irq)
    else $error("irq missing while done and enabled");

  a_chan_locked: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (cs_wr && state_q != ST_IDLE) |=> $stable(chan_q))
    else $error("channel changed while not idle");

  a_start_dropped: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (cs_wr && conv_done_flag && !result_rd)
      |=> conv_done_flag ##1 (state_q != ST_BUSY))
    else $error("blocked start not dropped");

  a_busy_ignores: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (conv_start_bit && cs_wr && !abort && !conv_last)
      |=> conv_start_bit && (busy_len_q == $past(busy_len_q) + 9'h001))
    else $error("start disturbed a running conversion");

  a_result_held: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    conv_done_flag |=> $stable(result_q))
    else $error("result changed while done set");

  a_read_clears: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (result_rd && conv_done_flag) |=> !conv_done_flag)
    else $error("result read did not clear done");

  a_abort_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (conv_start_bit && abort) |=> (state_q == ST_IDLE))
    else $error("conversion not aborted");

  a_idle_keeps: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (conv_done_flag && i_idle_mode && !result_rd) |=> conv_done_flag)
    else $error("idle lost completed result");

  a_pin_forced: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (req && wait_q && i_address == ADDR_PINS && en_q)
      |=> ((o_readdata[NUM_CHAN-1:0] & $past(chan_mask))
           == $past(chan_mask)))
    else $error("selected pin not read as one");

  a_idle_accepts: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == ST_IDLE && start_req) |=> conv_start_bit)
    else $error("start from idle not accepted");

  a_busy_reported: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (req && wait_q && i_address == ADDR_CS && conv_start_bit)
      |=> (o_readdata[BIT_START] && !o_readdata[BIT_DONE]))
    else $error("busy not reported on read");

  a_done_refuses: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (conv_done_flag && start_req) |=> !conv_start_bit)
    else $error("start accepted while done set");

  a_start_sticky: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (conv_start_bit && !abort && !conv_last) |=> conv_start_bit)
    else $error("start bit cleared early");

  a_digital_free: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !en_q |=> (o_pin_digital_en == PINS_ALL))
    else $error("pins not free while disabled");

  a_result_loaded: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == ST_POST) |=> (result_q == $past(i_sample_data)))
    else $error("result not stored at completion");

  a_irq_clears: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !conv_done_flag |=> !o_irq)
    else $error("irq high without done flag");

endmodule

/* logic/adcc_pkg.sv */
// Purpose: Shared constants and types for the converter control block
// Assumes: Avalon-MM word addressing by byte, 32-bit data
// Notes:   i_clk stands in for the oscillator clock
package adcc_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] ADDR_CS = 4'h0;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  localparam logic [3:0] ADDR_IRQEN = 4'h8;
  localparam logic [3:0] ADDR_PINS = 4'hC;

  // --------------------------------------------------------------
  // Field layout
  // --------------------------------------------------------------
  localparam int BIT_CHAN_LO = 0;
  localparam int BIT_CHAN_HI = 2;
  localparam int BIT_START = 3;
  localparam int BIT_DONE = 4;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_IRQEN = 0;
  localparam int NUM_CHAN = 5;
  localparam logic [7:0] CS_RSVD = 8'hC0;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [4:0] PINS_ALL = 5'h1F;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int OSC_PER_MC = 12;
  localparam int CONV_MC = 40;
  localparam logic [3:0] PRE_LAST = 4'(OSC_PER_MC - 1);
  localparam logic [5:0] MC_LAST = 6'(CONV_MC - 1);
  localparam logic [8:0] CONV_CLKS = 9'(CONV_MC * OSC_PER_MC);

  // Gray order along idle, busy, completing, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_POST = 2'h3,
    ST_DONE = 2'h2
  } adcc_state_t;

  // Channel code to one-hot pin mask; codes above 4 select nothing
  function automatic logic [4:0] adcc_onehot(input logic [2:0] sel);
    logic [4:0] m;
    m = 5'h00;
    case (sel)
      3'h0: m = 5'h01;
      3'h1: m = 5'h02;
      3'h2: m = 5'h04;
      3'h3: m = 5'h08;
      3'h4: m = 5'h10;
      default: m = 5'h00;
    endcase
    return m;
  endfunction

endpackage
